// ### common/tspg_defs.vh
`ifndef TSPG_DEFS_VH
`define TSPG_DEFS_VH

// Clock and time base
`define TSPG_CLK_NS 20
`define TSPG_TICK_US 1000
`define TSPG_MS_PER_S 15'd1000

// Timing in milliseconds
`define TSPG_SENS_STEP_MS 15'd50
`define TSPG_INR_STEP_MS 15'd50
`define TSPG_WDOG_MS 15'd5000
`define TSPG_PROG_MS 15'd30000

// Factory defaults
`define TSPG_DEF_SENS 3'h2
`define TSPG_DEF_RESTART 4'h4
`define TSPG_DEF_INRUSH 4'ha
`define TSPG_DEF_ADDR1 11'h064
`define TSPG_DEF_ADDR2 11'h065
`define TSPG_DEF_ADDR3 11'h066
`define TSPG_DEF_CTRL 32'h0000_0001

// Programming values
`define TSPG_PV_ENTER 8'h3e
`define TSPG_PV_RESET 8'h08
`define TSPG_PV_ADDR_LO 8'h01
`define TSPG_PV_ADDR_HI 8'h04
`define TSPG_PV_SENS_LO 8'h0b
`define TSPG_PV_SENS_HI 8'h11
`define TSPG_PV_RST_LO 8'h18
`define TSPG_PV_RST_HI 8'h1d
`define TSPG_PV_INR_LO 8'h1f
`define TSPG_PV_INR_HI 8'h23
`define TSPG_PV_ESR_OFF 8'h28
`define TSPG_PV_ESR_ON 8'h29
`define TSPG_PV_SC_ONE 8'h2a
`define TSPG_PV_SC_ALL 8'h2b
`define TSPG_SENS_BASE 8'h0a
`define TSPG_RST_BASE 8'h14
`define TSPG_INR_BASE 8'h19

// Register offsets
`define TSPG_REG_CTRL 12'h000
`define TSPG_REG_STATUS 12'h004
`define TSPG_REG_SETUP 12'h008
`define TSPG_REG_ADDR12 12'h00c
`define TSPG_REG_ADDR3W 12'h010

// Field positions
`define TSPG_CTRL_FB_EN 0
`define TSPG_ST_ESTOP 6
`define TSPG_ST_WDOG 7
`define TSPG_ST_PROG 8
`define TSPG_ST_ACT3 9
`define TSPG_SU_ESR 12
`define TSPG_SU_SCALL 13
`define TSPG_AD_WVALID 31

`endif

// ### logic/tspg_sync.v
`timescale 1ns/1ps
module tspg_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // Pins
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  // Change accepted only when stages two and three agree
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      o_sync <= INIT;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      o_sync <= (stage2 & stage3) | (o_sync & (stage2 ^ stage3));
    end
  end

endmodule

// ### logic/tspg_section.v
`timescale 1ns/1ps
module tspg_section (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // Control
  input wire i_tick,
  input wire i_en,
  input wire i_grp_trip,
  input wire i_clr_trip,
  // Sense
  input wire i_over,
  input wire i_volt_ok,
  // Times in ticks
  input wire [14:0] i_sens_t,
  input wire [14:0] i_inr_t,
  input wire [14:0] i_rst_t,
  // Status
  output wire o_power,
  output wire o_short,
  output reg o_trip
);

  localparam [3:0] S_OFF = 4'h1;
  localparam [3:0] S_INR = 4'h2;
  localparam [3:0] S_ON = 4'h4;
  localparam [3:0] S_TRIP = 4'h8;

  reg [3:0] state;
  reg [14:0] cnt;
  wire [14:0] cnt_inc = cnt + 15'h0001;

  assign o_power = state[1] | state[2];
  assign o_short = state[3];

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_OFF;
      cnt <= 15'h0000;
      o_trip <= 1'b0;
    end else begin
      o_trip <= 1'b0;
      case (state)
        S_OFF: begin
          cnt <= 15'h0000;
          if (i_en)
            state <= S_INR;
        end
        S_INR: begin
          if (!i_en) begin
            state <= S_OFF;
          end else if (i_grp_trip) begin
            state <= S_TRIP;
            cnt <= 15'h0000;
            o_trip <= 1'b1;
          end else if (i_tick) begin
            if (cnt_inc >= i_inr_t) begin
              cnt <= 15'h0000;
              // Apart from a group trip, only a lasting fault ends the inrush in a trip
              if (i_over && !i_volt_ok) begin
                state <= S_TRIP;
                o_trip <= 1'b1;
              end else begin
                state <= S_ON;
              end
            end else begin
              cnt <= cnt_inc;
            end
          end
        end
        S_ON: begin
          if (!i_en) begin
            state <= S_OFF;
          end else if (i_grp_trip) begin
            state <= S_TRIP;
            cnt <= 15'h0000;
            o_trip <= 1'b1;
          end else if (!i_over) begin
            cnt <= 15'h0000;
          end else if (i_tick) begin
            if (cnt_inc >= i_sens_t) begin
              state <= S_TRIP;
              cnt <= 15'h0000;
              o_trip <= 1'b1;
            end else begin
              cnt <= cnt_inc;
            end
          end
        end
        S_TRIP: begin
          if (i_clr_trip) begin
            state <= S_OFF;
            cnt <= 15'h0000;
          end else if (i_tick) begin
            if (cnt_inc >= i_rst_t) begin
              state <= i_en ? S_INR : S_OFF;
              cnt <= 15'h0000;
            end else begin
              cnt <= cnt_inc;
            end
          end
        end
        default: begin
          state <= S_OFF;
          cnt <= 15'h0000;
        end
      endcase
    end
  end

endmodule

// ### logic/tspg_top.v
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tspg_defs.vh"
module tspg_top #(
  parameter TICK_CYC = (`TSPG_TICK_US * 1000) / `TSPG_CLK_NS
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  // Decoded accessory commands
  input wire i_acc_valid,
  input wire [10:0] i_acc_addr,
  input wire i_acc_on,
  // Decoded programming values
  input wire i_pom_valid,
  input wire [7:0] i_pom_value,
  // Pins: straps, sense, button
  input wire [3:0] i_strap_n,
  input wire [2:0] i_over_lim,
  input wire [2:0] i_volt_ok,
  input wire i_estop_n,
  // Section drive and lamps
  output wire [2:0] o_sec_power,
  output reg [2:0] o_limit_high,
  output reg [2:0] o_led_power,
  output reg [2:0] o_led_short,
  output reg o_led_estop,
  output reg o_short_fb
);

  localparam integer TICK_LAST_I = TICK_CYC - 1;
  localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];
  localparam [3:0] P_IDLE = 4'h1;
  localparam [3:0] P_WAIT = 4'h2;
  localparam [3:0] P_ADDR = 4'h4;
  localparam [3:0] P_DONE = 4'h8;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and time base

  wire [10:0] pins_s;
  wire [3:0] strap_fit = ~pins_s[3:0];
  wire [2:0] over_s = pins_s[6:4];
  wire [2:0] volt_s = pins_s[9:7];
  wire estop = ~pins_s[10];
  wire active3 = ~strap_fit[3];
  reg estop_d;
  reg [15:0] tick_cnt;
  reg tick;

  tspg_sync #(.W(11), .INIT(11'h7ff)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_async({i_estop_n, i_volt_ok, i_over_lim, i_strap_n}),
    .o_sync(pins_s)
  );

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
      estop_d <= 1'b0;
    end else begin
      estop_d <= estop;
      tick <= (tick_cnt == TICK_LAST);
      if (tick_cnt == TICK_LAST)
        tick_cnt <= 16'h0000;
      else
        tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Programmed settings

  reg [3:0] pstate;
  reg [14:0] pcnt;
  reg [1:0] addr_sel;
  reg [2:0] sens_steps;
  reg [3:0] restart_s;
  reg [3:0] inrush_steps;
  reg opt_estop_rst;
  reg opt_short_all;
  reg [10:0] addr1;
  reg [10:0] addr2;
  reg [10:0] addr3;
  reg [10:0] addr_wd;
  reg wd_valid;
  wire [7:0] pv = i_pom_value;
  wire [7:0] sens_pv = pv - `TSPG_SENS_BASE;
  wire [7:0] rst_pv = pv - `TSPG_RST_BASE;
  wire [7:0] inr_pv = pv - `TSPG_INR_BASE;

  // Assignment consumes the accessory command, it switches nothing
  wire acc_assign = pstate[2] & i_acc_valid;
  wire acc_use = i_acc_valid & ~acc_assign;

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pstate <= P_IDLE;
      pcnt <= 15'h0000;
      addr_sel <= 2'h0;
      sens_steps <= `TSPG_DEF_SENS;
      restart_s <= `TSPG_DEF_RESTART;
      inrush_steps <= `TSPG_DEF_INRUSH;
      opt_estop_rst <= 1'b0;
      opt_short_all <= 1'b0;
      addr1 <= `TSPG_DEF_ADDR1;
      addr2 <= `TSPG_DEF_ADDR2;
      addr3 <= `TSPG_DEF_ADDR3;
      addr_wd <= 11'h000;
      wd_valid <= 1'b0;
    end else begin
      case (pstate)
        P_IDLE: begin
          pcnt <= 15'h0000;
          if (i_pom_valid && pv == `TSPG_PV_ENTER)
            pstate <= P_WAIT;
        end
        P_WAIT, P_ADDR: begin
          if (tick)
            pcnt <= pcnt + 15'h0001;
          if (pcnt >= `TSPG_PROG_MS) begin
            pstate <= P_IDLE;
          end else if (pstate[2]) begin
            if (acc_assign) begin
              pstate <= P_IDLE;
              case (addr_sel)
                2'h0: addr1 <= i_acc_addr;
                2'h1: addr2 <= i_acc_addr;
                2'h2: addr3 <= i_acc_addr;
                default: begin
                  addr_wd <= i_acc_addr;
                  wd_valid <= 1'b1;
                end
              endcase
            end
          end else if (i_pom_valid) begin
            pstate <= P_DONE;
            pcnt <= 15'h0000;
            if (pv == `TSPG_PV_RESET) begin
              sens_steps <= `TSPG_DEF_SENS;
              restart_s <= `TSPG_DEF_RESTART;
              inrush_steps <= `TSPG_DEF_INRUSH;
              opt_estop_rst <= 1'b0;
              opt_short_all <= 1'b0;
              addr1 <= `TSPG_DEF_ADDR1;
              addr2 <= `TSPG_DEF_ADDR2;
              addr3 <= `TSPG_DEF_ADDR3;
              wd_valid <= 1'b0;
            end else if (pv >= `TSPG_PV_ADDR_LO &&
                         pv <= `TSPG_PV_ADDR_HI) begin
              pstate <= P_ADDR;
              addr_sel <= pv[1:0] - 2'h1;
            end else if (pv >= `TSPG_PV_SENS_LO &&
                         pv <= `TSPG_PV_SENS_HI) begin
              sens_steps <= sens_pv[2:0];
            end else if (pv >= `TSPG_PV_RST_LO &&
                         pv <= `TSPG_PV_RST_HI) begin
              restart_s <= rst_pv[3:0];
            end else if (pv >= `TSPG_PV_INR_LO &&
                         pv <= `TSPG_PV_INR_HI) begin
              inrush_steps <= inr_pv[3:0];
            end else if (pv == `TSPG_PV_ESR_OFF ||
                         pv == `TSPG_PV_ESR_ON) begin
              opt_estop_rst <= pv[0];
            end else if (pv == `TSPG_PV_SC_ONE ||
                         pv == `TSPG_PV_SC_ALL) begin
              opt_short_all <= pv[0];
            end
          end
        end
        P_DONE: begin
          pstate <= P_IDLE;
        end
        default: begin
          pstate <= P_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Section switching and watchdog

  reg [2:0] sec_on;
  reg wd_en;
  reg [14:0] wd_cnt;
  wire wd_hit = acc_use & wd_valid & (i_acc_addr == addr_wd);
  wire wd_expire = wd_en & (wd_cnt >= `TSPG_WDOG_MS);

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sec_on <= 3'h7;
      wd_en <= 1'b0;
      wd_cnt <= 15'h0000;
    end else begin
      if (wd_hit) begin
        wd_en <= i_acc_on;
        wd_cnt <= 15'h0000;
      end else if (!wd_en || wd_expire) begin
        wd_cnt <= 15'h0000;
      end else if (tick) begin
        wd_cnt <= wd_cnt + 15'h0001;
      end
      if (wd_expire) begin
        sec_on <= 3'h0;
      end else if (acc_use) begin
        if (i_acc_addr == addr1)
          sec_on[0] <= i_acc_on;
        if (i_acc_addr == addr2)
          sec_on[1] <= i_acc_on;
        if (i_acc_addr == addr3)
          sec_on[2] <= i_acc_on;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sections

  wire [14:0] sens_t = {12'h000, sens_steps} * `TSPG_SENS_STEP_MS;
  wire [14:0] inr_t = {11'h000, inrush_steps} * `TSPG_INR_STEP_MS;
  wire [14:0] rst_t = {11'h000, restart_s} * `TSPG_MS_PER_S;
  wire [2:0] sec_act = {active3, 2'h3};
  wire [2:0] sec_en = sec_on & sec_act & {3{~estop}};
  wire [2:0] sec_short;
  wire [2:0] sec_trip;
  wire grp_trip = opt_short_all & (|sec_trip);
  wire clr_trip = opt_estop_rst & estop & ~estop_d;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sec
      tspg_section u_sec (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_tick(tick),
        .i_en(sec_en[gi]),
        .i_grp_trip(grp_trip),
        .i_clr_trip(clr_trip),
        .i_over(over_s[gi]),
        .i_volt_ok(volt_s[gi]),
        .i_sens_t(sens_t),
        .i_inr_t(inr_t),
        .i_rst_t(rst_t),
        .o_power(o_sec_power[gi]),
        .o_short(sec_short[gi]),
        .o_trip(sec_trip[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Lamps, limits, feedback and APB

  reg [31:0] ctrl;
  wire [31:0] status = {18'h0, strap_fit, active3, pstate[1] | pstate[2],
                        wd_en, estop, sec_short, o_sec_power};
  wire [31:0] setup = {18'h0, opt_short_all, opt_estop_rst, inrush_steps,
                       restart_s, 1'b0, sens_steps};
  wire [31:0] addr12 = {5'h00, addr2, 5'h00, addr1};
  wire [31:0] addr3w = {wd_valid, 4'h0, addr_wd, 5'h00, addr3};
  wire apb_acc = i_psel & i_penable;
  reg hit;
  reg [31:0] rd;

  assign o_pready = 1'b1;

  always @* begin
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (i_paddr)
      `TSPG_REG_CTRL: rd = ctrl;
      `TSPG_REG_STATUS: rd = status;
      `TSPG_REG_SETUP: rd = setup;
      `TSPG_REG_ADDR12: rd = addr12;
      `TSPG_REG_ADDR3W: rd = addr3w;
      default: hit = 1'b0;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= `TSPG_DEF_CTRL;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      o_limit_high <= 3'h0;
      o_led_power <= 3'h0;
      o_led_short <= 3'h0;
      o_led_estop <= 1'b0;
      o_short_fb <= 1'b0;
    end else begin
      // Read data registered at setup so it is valid in access
      o_prdata <= (i_psel && !i_penable) ? rd : o_prdata;
      o_pslverr <= i_psel & ~i_penable & ~hit;
      if (apb_acc && i_pwrite && i_paddr == `TSPG_REG_CTRL)
        ctrl <= {31'h0, i_pwdata[`TSPG_CTRL_FB_EN]};
      o_limit_high <= strap_fit[2:0];
      o_led_power <= o_sec_power & sec_act;
      o_led_short <= sec_short & sec_act;
      o_led_estop <= estop;
      o_short_fb <= ctrl[`TSPG_CTRL_FB_EN] & (|sec_short);
    end
  end

endmodule

// ### sim/tspg_assertions.sv
`timescale 1ns/1ps
module tspg_checker #(
  parameter TICK_CYC = 4
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // Watched inputs
  input wire i_psel,
  input wire i_penable,
  input wire [11:0] i_paddr,
  input wire i_acc_valid,
  input wire [10:0] i_acc_addr,
  input wire i_acc_on,
  input wire [3:0] i_strap_n,
  input wire i_estop_n,
  // Watched outputs
  input wire o_pready,
  input wire o_pslverr,
  input wire [2:0] o_sec_power,
  input wire [2:0] o_limit_high,
  input wire [2:0] o_led_short,
  input wire o_led_estop,
  input wire o_short_fb
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////////////////
  // Pins pass a three-flop filter, so causes are held eight cycles
  sequence s_estop_held;
    !i_estop_n [*8];
  endsequence
  sequence s_straps_still;
    $stable(i_strap_n) [*8];
  endsequence
  sequence s_off_cmd;
    i_acc_valid && !i_acc_on && i_acc_addr == 11'h064;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_pready_access: assert property (i_psel && i_penable |-> o_pready)
    else $error("pready low in access cycle");
  a_slverr_map: assert property (i_psel && i_penable |->
    o_pslverr == !(i_paddr inside {12'h000, 12'h004, 12'h008,
                                   12'h00c, 12'h010}))
    else $error("pslverr does not match address map");
  a_strap_limit: assert property (
    s_straps_still |-> o_limit_high == ~i_strap_n[2:0])
    else $error("limit select differs from straps");
  a_two_sections: assert property (
    (!i_strap_n[3]) [*8] |-> !o_sec_power[2])
    else $error("third section powered in two-section mode");
  a_estop_off: assert property (
    s_estop_held |-> o_sec_power == 3'h0)
    else $error("section powered while stop held");
  a_estop_lamp: assert property (s_estop_held |-> o_led_estop)
    else $error("stop lamp dark while stop held");
  a_off_cmd: assert property (s_off_cmd |-> ##[1:3] !o_sec_power[0])
    else $error("section one not switched off");
  a_fb_lamp: assert property (
    $rose(o_short_fb) |-> ##[0:2] (o_led_short != 3'h0))
    else $error("feedback without short lamp");
endmodule

bind tspg_top tspg_checker #(.TICK_CYC(TICK_CYC)) u_checker (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr), .i_acc_valid(i_acc_valid),
  .i_acc_addr(i_acc_addr), .i_acc_on(i_acc_on), .i_strap_n(i_strap_n),
  .i_estop_n(i_estop_n), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_sec_power(o_sec_power), .o_limit_high(o_limit_high),
  .o_led_short(o_led_short), .o_led_estop(o_led_estop),
  .o_short_fb(o_short_fb)
);

// ### sim/tspg_station.sv
`timescale 1ns/1ps
module tspg_station (
  // Clock
  input wire logic i_ref_clk,
  // Decoded commands
  output logic o_acc_valid,
  output logic [10:0] o_acc_addr,
  output logic o_acc_on,
  output logic o_pom_valid,
  output logic [7:0] o_pom_value
);
  initial begin
    o_acc_valid = 1'b0;
    o_acc_addr = 11'h000;
    o_acc_on = 1'b0;
    o_pom_valid = 1'b0;
    o_pom_value = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // Fields are inverted once released so stale values never match
  task send_acc(input logic [10:0] a, input logic on);
    @(posedge i_ref_clk);
    o_acc_valid <= 1'b1;
    o_acc_addr <= a;
    o_acc_on <= on;
    @(posedge i_ref_clk);
    o_acc_valid <= 1'b0;
    o_acc_addr <= ~a;
    o_acc_on <= ~on;
    repeat (3) @(posedge i_ref_clk);
  endtask
  task send_pom(input logic [7:0] v);
    @(posedge i_ref_clk);
    o_pom_valid <= 1'b1;
    o_pom_value <= v;
    @(posedge i_ref_clk);
    o_pom_valid <= 1'b0;
    o_pom_value <= ~v;
    repeat (3) @(posedge i_ref_clk);
  endtask
  // Gap given in cycles, kept below the expiry span
  task heartbeat(input logic [10:0] a, input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge i_ref_clk);
      send_acc(a, 1'b1);
    end
  endtask
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int T = 2;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [3:0] i_strap_n = 4'hf;
  logic [2:0] i_over_lim = 3'h0, i_volt_ok = 3'h7;
  logic i_estop_n = 1'b1;
  wire i_acc_valid, i_acc_on, i_pom_valid, o_pready, o_pslverr;
  wire [10:0] i_acc_addr;
  wire [7:0] i_pom_value;
  wire [31:0] o_prdata;
  wire [2:0] o_sec_power, o_limit_high, o_led_power, o_led_short;
  wire o_led_estop, o_short_fb;
  int fails = 0, check_count = 0, n;
  int sens = 2, rst = 4, inr = 10, esr = 0, sca = 0;
  logic [31:0] rd, d;
  logic err;
  logic [2:0] full, lim;

  always #10 i_ref_clk = ~i_ref_clk;

  tspg_top #(.TICK_CYC(T)) dut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_acc_valid(i_acc_valid),
    .i_acc_addr(i_acc_addr), .i_acc_on(i_acc_on),
    .i_pom_valid(i_pom_valid), .i_pom_value(i_pom_value),
    .i_strap_n(i_strap_n), .i_over_lim(i_over_lim),
    .i_volt_ok(i_volt_ok), .i_estop_n(i_estop_n),
    .o_sec_power(o_sec_power), .o_limit_high(o_limit_high),
    .o_led_power(o_led_power), .o_led_short(o_led_short),
    .o_led_estop(o_led_estop), .o_short_fb(o_short_fb));
  tspg_station stn (
    .i_ref_clk(i_ref_clk), .o_acc_valid(i_acc_valid),
    .o_acc_addr(i_acc_addr), .o_acc_on(i_acc_on),
    .o_pom_valid(i_pom_valid), .o_pom_value(i_pom_value));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] setup();
    return sens | (rst << 4) | (inr << 8) | (esr << 12) | (sca << 13);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Slack covers pin filter latency and tick phase
  task chk_ms(input int c, input int ms);
    chk(32'(c >= ms * T - 12 && c <= ms * T + 14), 32'h1);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    @(posedge i_ref_clk);
    while (o_pready !== 1'b1) @(posedge i_ref_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task wait_pwr(input logic [2:0] e, output int c);
    c = 0;
    while (o_sec_power !== e && c < 30000) begin
      @(posedge i_ref_clk);
      c++;
    end
  endtask
  task prog(input logic [7:0] v);
    stn.send_pom(8'h3e);
    stn.send_pom(v);
  endtask
  task estop_cycle();
    i_estop_n <= 1'b0;
    repeat (12) @(posedge i_ref_clk);
    chk(o_sec_power, 3'h0);
    chk(o_led_estop, 1'b1);
    i_estop_n <= 1'b1;
    wait_pwr(full, n);
    chk(32'(n < 40), 32'h1);
  endtask
  task print_verdict();
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #1800000;
    fails++;
    $display("unexpected at %0t: run timed out", $time);
    print_verdict();
  end
  initial begin
    void'($urandom(32343));
    i_strap_n <= 4'($urandom);
    repeat (16) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (12) @(posedge i_ref_clk);
    full = {i_strap_n[3], 2'b11};
    lim = ~i_strap_n[2:0];
    chk(o_sec_power, full);
    chk(o_limit_high, lim);
    chk(o_led_power, full);
    apb(1'b0, 12'h000, 0);
    chk(rd, 32'h1);
    d = $urandom;
    apb(1'b1, 12'h000, d);
    apb(1'b0, 12'h000, 0);
    chk(rd, d & 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h008, $urandom);
    apb(1'b0, 12'h008, 0);
    chk(rd, setup());
    apb(1'b0, 12'h00c, 0);
    chk(rd, 32'h0065_0064);
    apb(1'b0, 12'h014, 0);
    chk({rd[30:0], err}, 32'h1);
    prog(8'h0d);
    sens = 3;
    apb(1'b0, 12'h008, 0);
    chk(rd, setup());
    repeat (1100 * T) @(posedge i_ref_clk);
    i_over_lim[0] <= 1'b1;
    repeat ((sens * 50 - 20) * T) @(posedge i_ref_clk);
    i_over_lim[0] <= 1'b0;
    repeat (20) @(posedge i_ref_clk);
    chk(o_sec_power, full);
    i_over_lim[0] <= 1'b1;
    wait_pwr(full & 3'h6, n);
    chk_ms(n, sens * 50);
    chk(o_sec_power, full & 3'h6);
    repeat (4) @(posedge i_ref_clk);
    chk(o_led_short, 3'h1);
    chk(o_short_fb, 1'b1);
    i_over_lim[0] <= 1'b0;
    wait_pwr(full, n);
    chk_ms(n, rst * 1000);
    i_over_lim[0] <= 1'b1;
    i_volt_ok[0] <= 1'b0;
    repeat (200 * T) @(posedge i_ref_clk);
    i_over_lim[0] <= 1'b0;
    i_volt_ok[0] <= 1'b1;
    repeat (1000 * T) @(posedge i_ref_clk);
    chk(o_sec_power, full);
    stn.send_acc(11'h064, 1'b0);
    chk(o_sec_power, full & 3'h6);
    i_over_lim[0] <= 1'b1;
    i_volt_ok[0] <= 1'b0;
    stn.send_acc(11'h064, 1'b1);
    chk(o_sec_power, full);
    wait_pwr(full & 3'h6, n);
    chk_ms(n, inr * 50);
    i_over_lim[0] <= 1'b0;
    i_volt_ok[0] <= 1'b1;
    prog(8'h29);
    esr = 1;
    estop_cycle();
    prog(8'h2b);
    sca = 1;
    apb(1'b0, 12'h008, 0);
    chk(rd, setup());
    repeat (1100 * T) @(posedge i_ref_clk);
    i_over_lim[1] <= 1'b1;
    wait_pwr(3'h0, n);
    chk_ms(n, sens * 50);
    i_over_lim[1] <= 1'b0;
    estop_cycle();
    prog(8'h04);
    stn.send_acc(11'h0c8, 1'b1);
    stn.send_acc(11'h0c8, 1'b1);
    apb(1'b0, 12'h004, 0);
    chk(rd[7], 1'b1);
    stn.heartbeat(11'h0c8, 3, 4000 * T);
    chk(o_sec_power, full);
    wait_pwr(3'h0, n);
    chk_ms(n, 5000);
    stn.send_acc(11'h0c8, 1'b0);
    apb(1'b0, 12'h004, 0);
    chk(rd[7], 1'b0);
    prog(8'h1d);
    rst = 9;
    prog(8'h1f);
    inr = 6;
    apb(1'b0, 12'h008, 0);
    chk(rd, setup());
    prog(8'h08);
    sens = 2;
    rst = 4;
    inr = 10;
    esr = 0;
    sca = 0;
    apb(1'b0, 12'h008, 0);
    chk(rd, setup());
    print_verdict();
  end
endmodule
